// ---- include/caf_pkg.sv ----
// shared constants and types for the receive acceptance filter
`default_nettype none
package caf_pkg;
	localparam int NUM_FILT_MAX = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int ID_W = 32;
	// register byte addresses
	localparam logic [7:0] ADDR_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK_BASE = 8'h10;
	localparam logic [7:0] ADDR_IDENT_BASE = 8'h20;
	localparam logic [7:0] ADDR_PAIR_STRIDE = 8'h04;
	// filter table lives in 0x10..0x2F
	localparam logic [7:0] ADDR_TABLE_LO = 8'h10;
	localparam logic [7:0] ADDR_TABLE_HI = 8'h2F;
	localparam logic [7:0] ADDR_IDENT_SEL = 8'h20;
	// enable register layout
	localparam int ENABLE_LSB = 0;
	localparam int ENABLE_MSB = 3;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	// status register layout
	localparam int STATUS_BUSY_BIT = 0;
	// identifier word field positions
	localparam int FLD_BASE_MSB = 31;
	localparam int FLD_BASE_LSB = 21;
	localparam int FLD_SRR_BIT = 20;
	localparam int FLD_IDE_BIT = 19;
	localparam int FLD_EXT_MSB = 18;
	localparam int FLD_EXT_LSB = 1;
	localparam int FLD_RTR_BIT = 0;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	// evaluation states
	typedef enum logic [1:0] {CAF_IDLE, CAF_FRAME, CAF_DECIDE} caf_state_t;
	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} caf_bus_req_t;
	// receive engine frame events
	typedef struct packed {
		logic sof;
		logic id_valid;
		logic [ID_W-1:0] ident;
		logic eof_ok;
		logic abort;
	} caf_rx_evt_t;
endpackage : caf_pkg
`default_nettype wire

// ---- hdl/caf_pair_table.sv ----
// mask and identifier storage for four filter pairs, not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module caf_pair_table #(
	parameter int NUM_PAIRS = 4
) (
	input wire logic i_clk,
	input wire logic i_wr,
	input wire logic i_sel_ident,
	input wire logic [1:0] i_wsel,
	input wire logic [31:0] i_wdata,
	input wire logic [1:0] i_rsel,
	input wire logic i_rsel_ident,
	output logic [31:0] o_rdata,
	output logic [NUM_PAIRS*32-1:0] o_masks,
	output logic [NUM_PAIRS*32-1:0] o_idents
);
	logic [31:0] mask_mem [NUM_PAIRS];
	logic [31:0] ident_mem [NUM_PAIRS];

	// storage with no reset so contents outlive any reset
	always_ff @(posedge i_clk) begin
		if (i_wr && !i_sel_ident) begin
			mask_mem[i_wsel] <= i_wdata;
		end
		if (i_wr && i_sel_ident) begin
			ident_mem[i_wsel] <= i_wdata;
		end
	end

	// registered read port, data one cycle after strobe
	always_ff @(posedge i_clk) begin
		o_rdata <= i_rsel_ident ? ident_mem[i_rsel] : mask_mem[i_rsel];
	end

	// flat view for the comparators
	genvar g;
	generate
		for (g = 0; g < NUM_PAIRS; g++) begin : g_flat
			assign o_masks[g*32 +: 32] = mask_mem[g];
			assign o_idents[g*32 +: 32] = ident_mem[g];
		end
	endgenerate
endmodule : caf_pair_table
`default_nettype wire

// ---- hdl/caf_match.sv ----
// masked compare of one received identifier against all filter pairs
`timescale 1ns/1ps
`default_nettype none
module caf_match #(
	parameter int NUM_PAIRS = 4
) (
	input wire logic [31:0] i_ident,
	input wire logic [NUM_PAIRS*32-1:0] i_masks,
	input wire logic [NUM_PAIRS*32-1:0] i_idents,
	input wire logic [NUM_PAIRS-1:0] i_enable,
	output logic [NUM_PAIRS-1:0] o_hit,
	output logic o_accept
);
	// a mask bit of one makes that bit count, zero ignores it
	genvar g;
	generate
		for (g = 0; g < NUM_PAIRS; g++) begin : g_cmp
			logic [31:0] m;
			assign m = i_masks[g*32 +: 32];
			assign o_hit[g] = i_enable[g]
				&& ((i_ident & m) == (i_idents[g*32 +: 32] & m));
		end
	endgenerate

	// any active hit accepts; no active filter accepts all
	assign o_accept = (i_enable == '0) || (|o_hit);
endmodule : caf_match
`default_nettype wire

// ---- hdl/caf_filter.sv ----
// receive acceptance filter: enable register, pair table and per-frame decision
`timescale 1ns/1ps
`default_nettype none
module caf_filter #(
	parameter int NUM_FILTERS = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire caf_pkg::caf_bus_req_t i_bus,
	output logic [31:0] o_rdata,
	input wire caf_pkg::caf_rx_evt_t i_rx,
	output logic o_fifo_wr,
	output logic o_frame_drop,
	output logic [3:0] o_hit,
	output logic o_busy
);
	localparam int NP = caf_pkg::NUM_FILT_MAX;
	// configured pairs as a bit vector, zero when no filters
	localparam logic [NP-1:0] CFG_MASK = 4'((1 << NUM_FILTERS) - 1);
	localparam bit HAS_FILT = (NUM_FILTERS > 0);

	caf_pkg::caf_state_t state_r;
	logic [NP-1:0] enable_r;
	logic [NP-1:0] frame_en_r;
	logic fell_r;
	logic [31:0] ident_r;
	logic [NP-1:0] hit;
	logic accept;
	logic [NP*32-1:0] masks;
	logic [NP*32-1:0] idents;
	logic [31:0] tbl_rdata;
	logic in_table;
	logic tbl_wr;
	logic [1:0] tbl_sel;
	logic sel_ident;
	logic [31:0] reg_rdata_r;
	logic rd_table_r;
	logic rd_any_r;
	logic [7:0] offs;

	// address decode of the pair table
	assign in_table = (i_bus.addr >= caf_pkg::ADDR_TABLE_LO)
		&& (i_bus.addr <= caf_pkg::ADDR_TABLE_HI);
	assign offs = i_bus.addr - caf_pkg::ADDR_MASK_BASE;
	assign tbl_sel = offs[3:2];
	assign sel_ident = (i_bus.addr >= caf_pkg::ADDR_IDENT_SEL);
	assign tbl_wr = i_bus.wr && in_table && HAS_FILT;

	// mask and identifier storage for every pair
	caf_pair_table #(
		.NUM_PAIRS(NP)
	) u_table (
		.i_clk(i_clk),
		.i_wr(tbl_wr),
		.i_sel_ident(sel_ident),
		.i_wsel(tbl_sel),
		.i_wdata(i_bus.wdata),
		.i_rsel(tbl_sel),
		.i_rsel_ident(sel_ident),
		.o_rdata(tbl_rdata),
		.o_masks(masks),
		.o_idents(idents)
	);

	// comparators against the captured identifier
	caf_match #(
		.NUM_PAIRS(NP)
	) u_match (
		.i_ident(ident_r),
		.i_masks(masks),
		.i_idents(idents),
		.i_enable(frame_en_r & enable_r),
		.o_hit(hit),
		.o_accept(accept)
	);

	// enable register, unconfigured bits never stored
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			enable_r <= caf_pkg::ENABLE_RESET[NP-1:0];
		end else if (i_bus.wr && i_bus.addr == caf_pkg::ADDR_ENABLE && HAS_FILT) begin
			enable_r <= i_bus.wdata[caf_pkg::ENABLE_MSB:caf_pkg::ENABLE_LSB]
				& CFG_MASK;
		end
	end

	// frame sequencing: open on start, capture id, decide at end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= caf_pkg::CAF_IDLE;
		end else begin
			case (state_r)
				caf_pkg::CAF_IDLE: begin
					if (i_rx.sof) begin
						state_r <= caf_pkg::CAF_FRAME;
					end
				end
				caf_pkg::CAF_FRAME: begin
					if (i_rx.abort) begin
						state_r <= caf_pkg::CAF_IDLE;
					end else if (i_rx.eof_ok) begin
						state_r <= caf_pkg::CAF_DECIDE;
					end
				end
				caf_pkg::CAF_DECIDE: begin
					state_r <= caf_pkg::CAF_IDLE;
				end
				default: begin
					state_r <= caf_pkg::CAF_IDLE;
				end
			endcase
		end
	end

	// identifier capture from the receive engine
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ident_r <= 32'h0000_0000;
		end else if (state_r == caf_pkg::CAF_FRAME && i_rx.id_valid) begin
			ident_r <= i_rx.ident;
		end
	end

	// enable snapshot at frame start and fall detection during the frame
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			frame_en_r <= 4'h0;
			fell_r <= 1'b0;
		end else if (state_r == caf_pkg::CAF_IDLE && i_rx.sof) begin
			frame_en_r <= enable_r;
			fell_r <= 1'b0;
		end else if (state_r == caf_pkg::CAF_FRAME) begin
			if ((frame_en_r & ~enable_r) != 4'h0) begin
				fell_r <= 1'b1;
			end
		end
	end

	// one fifo write strobe per accepted frame
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fifo_wr <= 1'b0;
			o_frame_drop <= 1'b0;
			o_hit <= 4'h0;
		end else if (state_r == caf_pkg::CAF_DECIDE) begin
			o_fifo_wr <= accept && !fell_r;
			o_frame_drop <= !(accept && !fell_r);
			o_hit <= hit;
		end else begin
			o_fifo_wr <= 1'b0;
			o_frame_drop <= 1'b0;
		end
	end

	// busy while a frame is open or being decided
	assign o_busy = (state_r != caf_pkg::CAF_IDLE);

	// register read data, one cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			reg_rdata_r <= 32'h0000_0000;
			rd_table_r <= 1'b0;
			rd_any_r <= 1'b0;
		end else begin
			rd_any_r <= i_bus.rd;
			rd_table_r <= i_bus.rd && in_table && HAS_FILT;
			reg_rdata_r <= 32'h0000_0000;
			if (i_bus.rd && i_bus.addr == caf_pkg::ADDR_ENABLE && HAS_FILT) begin
				reg_rdata_r <= {28'h0000000, enable_r & CFG_MASK};
			end else if (i_bus.rd && i_bus.addr == caf_pkg::ADDR_STATUS) begin
				reg_rdata_r[caf_pkg::STATUS_BUSY_BIT] <= o_busy;
			end
		end
	end

	// read mux, zero outside a read answer cycle
	always_comb begin
		o_rdata = 32'h0000_0000;
		if (rd_table_r) begin
			o_rdata = tbl_rdata;
		end else if (rd_any_r) begin
			o_rdata = reg_rdata_r;
		end
	end
endmodule : caf_filter
`default_nettype wire

// ---- testbench/caf_filter_assertions.sv ----
// port assertions for the acceptance filter
`timescale 1ns/1ps
`default_nettype none
module caf_filter_assertions #(
	parameter int NUM_FILTERS = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire caf_pkg::caf_bus_req_t i_bus,
	input wire logic [31:0] o_rdata,
	input wire caf_pkg::caf_rx_evt_t i_rx,
	input wire logic o_fifo_wr,
	input wire logic o_frame_drop,
	input wire logic [3:0] o_hit,
	input wire logic o_busy
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// bus answers and frame decisions
	rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
		else $error("read data outside slot");
	enable_rsvd_a: assert property ($past(i_bus.rd)
		&& $past(i_bus.addr) == caf_pkg::ADDR_ENABLE |-> (o_rdata >> NUM_FILTERS) == 32'h0)
		else $error("enable high bits not zero");
	status_busy_a: assert property ($past(i_bus.rd)
		&& $past(i_bus.addr) == caf_pkg::ADDR_STATUS |-> o_rdata[0] == $past(o_busy))
		else $error("status busy bit wrong");
	decide_lat_a: assert property (i_rx.eof_ok && o_busy
		|-> ##2 (o_fifo_wr || o_frame_drop))
		else $error("no decision");
	one_outcome_a: assert property (!(o_fifo_wr && o_frame_drop))
		else $error("store and drop together");
	out_cause_a: assert property (o_fifo_wr || o_frame_drop |-> $past(i_rx.eof_ok, 2))
		else $error("decision without frame end");
	abort_quiet_a: assert property (i_rx.abort && o_busy
		|-> ##2 !(o_fifo_wr || o_frame_drop))
		else $error("decision after abort");
	hit_range_a: assert property ((o_hit >> NUM_FILTERS) == 4'h0)
		else $error("hit on absent filter");
	busy_start_a: assert property (i_rx.sof && !o_busy |=> o_busy)
		else $error("busy missing after start");
	cover property (o_fifo_wr);
	cover property (o_frame_drop);
	cover property (i_rx.abort && o_busy);
endmodule : caf_filter_assertions
bind caf_filter caf_filter_assertions #(.NUM_FILTERS(NUM_FILTERS)) u_chk (.i_clk(i_clk),
	.i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_rx(i_rx), .o_fifo_wr(o_fifo_wr),
	.o_frame_drop(o_frame_drop), .o_hit(o_hit), .o_busy(o_busy));
`default_nettype wire

// ---- testbench/caf_rx_engine.sv ----
// receive engine model sending frame events
`timescale 1ns/1ps
`default_nettype none
module caf_rx_engine (
	input wire logic i_clk,
	output caf_pkg::caf_rx_evt_t o_rx
);
	initial o_rx = '0;
	// start, one id word, gap, then end or abort
	task automatic send(input logic [31:0] id, input logic ok, input int gap);
		@(posedge i_clk);
		o_rx.sof <= 1'b1;
		@(posedge i_clk);
		o_rx.sof <= 1'b0;
		o_rx.id_valid <= 1'b1;
		o_rx.ident <= id;
		@(posedge i_clk);
		o_rx.id_valid <= 1'b0;
		o_rx.ident <= ~id; // stale word must not look valid
		repeat (gap) @(posedge i_clk);
		o_rx.eof_ok <= ok;
		o_rx.abort <= !ok;
		@(posedge i_clk);
		o_rx.eof_ok <= 1'b0;
		o_rx.abort <= 1'b0;
	endtask : send
endmodule : caf_rx_engine
`default_nettype wire

// ---- testbench/caf_filter_bench.sv ----
// self-checking bench for the acceptance filter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module caf_filter_bench;
	localparam logic [7:0] EN = caf_pkg::ADDR_ENABLE;
	logic clk;
	logic rst;
	caf_pkg::caf_bus_req_t bus;
	logic [31:0] rdata;
	caf_pkg::caf_rx_evt_t rx;
	logic fifo_wr;
	logic drop;
	logic [3:0] hit;
	logic busy;
	int n_mismatch;
	int n_compared;
	caf_filter #(.NUM_FILTERS(3)) u_caf_filter (.i_clk(clk), .i_rst(rst), .i_bus(bus),
		.o_rdata(rdata), .i_rx(rx), .o_fifo_wr(fifo_wr), .o_frame_drop(drop), .o_hit(hit),
		.o_busy(busy));
	caf_rx_engine u_caf_rx_engine (.i_clk(clk), .o_rx(rx));
	// bus write and read, one idle cycle after each
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		`CHK("rdata", ex, rdata)
		@(posedge clk);
	endtask : rd
	// one frame, outcome as {store, drop}
	task automatic frame(input logic [31:0] id, input logic ok, input int gap,
		input logic [1:0] ex);
		logic [1:0] seen;
		seen = 2'b00;
		u_caf_rx_engine.send(id, ok, gap);
		repeat (5) begin
			@(negedge clk);
			seen = seen | {fifo_wr, drop};
		end
		`CHK("outcome", ex, seen)
		@(posedge clk);
	endtask : frame
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		bus = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(EN, 32'h0);
		rd(8'h08, 32'h0);
		rd(caf_pkg::ADDR_STATUS, 32'h0);
		wr(EN, 32'hFFFF_FFFF);
		rd(EN, 32'h7);
		wr(EN, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h10 + 8'(4 * i), 32'hFFE0_0000);
			wr(8'h20 + 8'(4 * i), 32'(i + 1) << 21);
		end
		for (int i = 0; i < 4; i++) begin
			rd(8'h10 + 8'(4 * i), 32'hFFE0_0000);
			rd(8'h20 + 8'(4 * i), 32'(i + 1) << 21);
		end
		$display("register test done");
		frame(32'h1234_5678, 1'b1, 1, 2'b10);
		wr(EN, 32'h1);
		frame(32'h003F_FFFF, 1'b1, 1, 2'b10);
		`CHK("hit", 4'h1, hit)
		frame(32'h0040_0000, 1'b1, 1, 2'b01);
		wr(EN, 32'hE);
		frame(32'h0040_0000, 1'b1, 0, 2'b10);
		`CHK("hit", 4'h2, hit)
		frame(32'h0080_0000, 1'b1, 1, 2'b01);
		frame(32'h0040_0000, 1'b0, 1, 2'b00);
		fork
			frame(32'h0040_0000, 1'b1, 4, 2'b01);
			begin
				repeat (3) @(posedge clk);
				wr(EN, 32'h0);
				rd(caf_pkg::ADDR_STATUS, 32'h0000_0001);
			end
		join
		$display("frame test done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h10, 32'hFFE0_0000);
		rd(EN, 32'h0);
		$display("reset test done");
		stop_test();
	end
endmodule : caf_filter_bench
`default_nettype wire
